//--- hw/vout_limit_regs.vh
// Command codes, word layouts, defaults and limits of the output settings
`ifndef VOUT_LIMIT_REGS_VH
`define VOUT_LIMIT_REGS_VH
`define CMD_STORE_ALL 8'h11
`define CMD_CEILING 8'h24
`define CMD_SLEW 8'h27
`define CMD_SCALE 8'h29
`define SLEW_EXP 5'h1A
`define SLEW_PAD 4'h0
`define SLEW_RST 7'h3C
`define SCALE_EXP 5'h1E
`define SCALE_PAD 8'h00
`define SCALE_X1 3'h4
`define SCALE_X05 3'h2
`define SCALE_X025 3'h1
`define SCALE_RST 3'h4
`define CEIL_PAD 4'h0
`define CEIL_RST 12'h34D
`define CEIL_MIN_X1 12'h11A
`define CEIL_MAX_X1 12'h34D
`define CEIL_MIN_X05 12'h234
`define CEIL_MAX_X05 12'h69A
`define CEIL_MIN_X025 12'h468
`define CEIL_MAX_X025 12'hC00
`define SLEW_TOP_0 7'h05
`define SLEW_TOP_1 7'h07
`define SLEW_TOP_2 7'h0C
`define SLEW_TOP_3 7'h11
`define SLEW_TOP_4 7'h19
`define SLEW_TOP_5 7'h2F
`define SLEW_TOP_6 7'h4F
`define REF_LSB 2
`define NO_DATA 8'hFF
`endif

//--- hw/smbus_bit_engine.v
// Two-wire slave bit engine: framing, address match, byte shift and ack
`timescale 1ns/1ps
module smbus_bit_engine #(
  parameter [6:0] DEV_ADDR = 7'h24
) (
  input wire clk,
  input wire rst,
  input wire scl_pin,
  input wire sda_pin,
  output wire sda_out,
  output wire sda_oe_n,
  input wire ack_ok,
  input wire [7:0] tx_data,
  output wire rx_pulse,
  output wire [7:0] rx_data,
  output wire rx_first,
  output wire tx_req,
  output wire tx_first,
  output wire stop_pulse
);
  localparam S_IDLE = 5'b00001;
  localparam S_ADDR = 5'b00010;
  localparam S_WR = 5'b00100;
  localparam S_RD = 5'b01000;
  localparam S_SKIP = 5'b10000;
  reg scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  reg [4:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] shift_q;
  reg drive_q, hit_q, read_q, first_q, mnack_q;
  reg rx_q, rxf_q, txr_q, txf_q, stop_q;
  reg [7:0] rxd_q;
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire [7:0] byte_in = {shift_q[6:0], sda_s_q};
  wire addr_hit = (byte_in[7:1] == DEV_ADDR);

  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_q;
  assign rx_pulse = rx_q;
  assign rx_data = rxd_q;
  assign rx_first = rxf_q;
  assign tx_req = txr_q;
  assign tx_first = txf_q;
  assign stop_pulse = stop_q;

  always @(posedge clk) begin
    if (rst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      {drive_q, hit_q, read_q, first_q, mnack_q} <= 5'h00;
      {rx_q, rxf_q, txr_q, txf_q, stop_q} <= 5'h00;
      rxd_q <= 8'h00;
    end else begin
      scl_m_q <= scl_pin;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_pin;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      rx_q <= 1'b0;
      txr_q <= 1'b0;
      stop_q <= 1'b0;
      if (stop_c) begin
        state_q <= S_IDLE;
        drive_q <= 1'b0;
        stop_q <= 1'b1;
      end else if (start_c) begin
        state_q <= S_ADDR;
        // Parked so the start's own clock fall is not taken as a bit
        cnt_q <= 4'hF;
        drive_q <= 1'b0;
      end else if (scl_rise) begin
        if (cnt_q < 4'h8 && (state_q == S_ADDR || state_q == S_WR)) begin
          shift_q <= byte_in;
          if (cnt_q == 4'h7 && state_q == S_ADDR) begin
            hit_q <= addr_hit;
            read_q <= byte_in[0];
            txr_q <= addr_hit & byte_in[0];
            txf_q <= 1'b1;
          end else if (cnt_q == 4'h7) begin
            rx_q <= 1'b1;
            rxd_q <= byte_in;
            rxf_q <= first_q;
          end
        end else if (state_q == S_RD && cnt_q == 4'h8) begin
          mnack_q <= sda_s_q;
          txr_q <= ~sda_s_q;
          txf_q <= 1'b0;
        end
      end else if (scl_fall) begin
        case (state_q)
          S_ADDR: begin
            if (cnt_q == 4'h7) begin
              cnt_q <= 4'h8;
              drive_q <= hit_q;
            end else if (cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              drive_q <= 1'b0;
              if (!hit_q) begin
                state_q <= S_SKIP;
              end else if (read_q) begin
                state_q <= S_RD;
                shift_q <= tx_data;
                drive_q <= ~tx_data[7];
              end else begin
                state_q <= S_WR;
                first_q <= 1'b1;
              end
            end else if (cnt_q == 4'hF) begin
              cnt_q <= 4'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
          S_WR: begin
            if (cnt_q == 4'h7) begin
              cnt_q <= 4'h8;
              drive_q <= ack_ok;
            end else if (cnt_q == 4'h8) begin
              // A refused byte ends our part in the frame
              cnt_q <= 4'h0;
              drive_q <= 1'b0;
              first_q <= 1'b0;
              if (!drive_q) begin
                state_q <= S_SKIP;
              end
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
          S_RD: begin
            if (cnt_q < 4'h7) begin
              shift_q <= {shift_q[6:0], 1'b0};
              drive_q <= ~shift_q[6];
              cnt_q <= cnt_q + 4'h1;
            end else if (cnt_q == 4'h7) begin
              drive_q <= 1'b0;
              cnt_q <= 4'h8;
            end else if (mnack_q) begin
              state_q <= S_SKIP;
            end else begin
              cnt_q <= 4'h0;
              shift_q <= tx_data;
              drive_q <= ~tx_data[7];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule // smbus_bit_engine

//--- hw/vout_limit_slew_scale_regs.v
// Output ceiling, slew and loop-scale command words behind the bus slave
`timescale 1ns/1ps
`include "vout_limit_regs.vh"
module vout_limit_slew_scale_regs #(
  parameter [6:0] DEV_ADDR = 7'h24
) (
  input wire clk,
  input wire rst,
  input wire scl_pin,
  input wire sda_pin,
  output wire sda_out,
  output wire sda_oe_n,
  output wire smbalert_out,
  output wire smbalert_oe_n,
  input wire loop_slave_pin,
  input wire output_on,
  input wire soft_start,
  input wire turn_off,
  input wire [2:0] ton_rise_code,
  input wire [2:0] toff_fall_code,
  input wire [11:0] target_req,
  input wire target_load,
  input wire clear_faults,
  output wire [2:0] ramp_rate_code,
  output wire [11:0] ref_code,
  output wire [11:0] ceiling,
  output wire [2:0] scale_mant,
  output wire nvm_store,
  output wire [2:0] nvm_scale,
  output wire cml_flag,
  output wire ivd_flag,
  output wire invalid_command_fault,
  output wire oth_flag,
  output wire vfw_flag,
  output wire vout_maxmin_warn
);
  reg slave_m_q, slave_s_q;
  reg [11:0] ceil_q;
  reg [6:0] slew_q;
  reg [2:0] scale_q, nvm_q;
  reg [11:0] target_q, ref_q;
  reg [2:0] ramp_q;
  reg [7:0] cmd_q, lo_q, tx_q;
  reg [1:0] idx_q, ridx_q;
  reg ack_q, store_q, limit_chg_q;
  reg cml_q, ivd_q, ivc_q, oth_q, vfw_q, warn_q, alert_q;
  reg set_ivc, set_bad, set_warn;
  wire rx_pulse, rx_first, tx_req, tx_first;
  wire [7:0] rx_data;
  wire [15:0] word = {rx_data, lo_q};
  wire [11:0] lim = (target_q > ceil_q) ? ceil_q : target_q;
  wire [14:0] prod = {3'h0, lim} * {12'h000, scale_q};
  // A load is judged by the incoming target, not the stale one
  wire over = output_on & ((target_load ? target_req : target_q) > ceil_q);
  wire [15:0] rd_word = read_word(cmd_q);

  function [2:0] rate_bucket;
    input [6:0] m;
    begin
      if (m <= `SLEW_TOP_0) rate_bucket = 3'h0;
      else if (m <= `SLEW_TOP_1) rate_bucket = 3'h1;
      else if (m <= `SLEW_TOP_2) rate_bucket = 3'h2;
      else if (m <= `SLEW_TOP_3) rate_bucket = 3'h3;
      else if (m <= `SLEW_TOP_4) rate_bucket = 3'h4;
      else if (m <= `SLEW_TOP_5) rate_bucket = 3'h5;
      else if (m <= `SLEW_TOP_6) rate_bucket = 3'h6;
      else rate_bucket = 3'h7;
    end
  endfunction

  function ceil_ok;
    input [11:0] m;
    input [2:0] s;
    begin
      case (s)
        `SCALE_X1: ceil_ok = m >= `CEIL_MIN_X1 && m <= `CEIL_MAX_X1;
        `SCALE_X05: ceil_ok = m >= `CEIL_MIN_X05 && m <= `CEIL_MAX_X05;
        `SCALE_X025: ceil_ok = m >= `CEIL_MIN_X025 && m <= `CEIL_MAX_X025;
        default: ceil_ok = 1'b0;
      endcase
    end
  endfunction

  function [11:0] ceil_default;
    input [2:0] s;
    begin
      case (s)
        `SCALE_X05: ceil_default = `CEIL_MAX_X05;
        `SCALE_X025: ceil_default = `CEIL_MAX_X025;
        default: ceil_default = `CEIL_MAX_X1;
      endcase
    end
  endfunction

  function [15:0] read_word;
    input [7:0] c;
    begin
      case (c)
        `CMD_CEILING: read_word = {`CEIL_PAD, ceil_q};
        `CMD_SLEW: read_word = {`SLEW_EXP, `SLEW_PAD, slew_q};
        `CMD_SCALE: read_word = {`SCALE_EXP, `SCALE_PAD, scale_q};
        default: read_word = {`NO_DATA, `NO_DATA};
      endcase
    end
  endfunction

  function cmd_known;
    input [7:0] c;
    begin
      cmd_known = c == `CMD_CEILING || c == `CMD_SLEW || c == `CMD_SCALE ||
        c == `CMD_STORE_ALL;
    end
  endfunction

  function scale_legal;
    input [15:0] w;
    begin
      scale_legal = w[15:3] == {`SCALE_EXP, `SCALE_PAD} &&
        (w[2:0] == `SCALE_X1 || w[2:0] == `SCALE_X05 ||
        w[2:0] == `SCALE_X025);
    end
  endfunction

  smbus_bit_engine #(
    .DEV_ADDR(DEV_ADDR)
  ) u_engine (
    .clk(clk),
    .rst(rst),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .ack_ok(ack_q),
    .tx_data(tx_q),
    .rx_pulse(rx_pulse),
    .rx_data(rx_data),
    .rx_first(rx_first),
    .tx_req(tx_req),
    .tx_first(tx_first),
    .stop_pulse()
  );

  assign smbalert_out = 1'b0;
  assign smbalert_oe_n = ~alert_q;
  assign ramp_rate_code = ramp_q;
  assign ref_code = ref_q;
  assign ceiling = ceil_q;
  assign scale_mant = scale_q;
  assign nvm_store = store_q;
  assign nvm_scale = nvm_q;
  assign cml_flag = cml_q;
  assign ivd_flag = ivd_q;
  assign invalid_command_fault = ivc_q;
  assign oth_flag = oth_q;
  assign vfw_flag = vfw_q;
  assign vout_maxmin_warn = warn_q;

  // Event decode; flags are set below so a set beats a same-cycle clear
  always @* begin
    set_ivc = 1'b0;
    set_bad = 1'b0;
    set_warn = over & (target_load | limit_chg_q);
    if (rx_pulse && rx_first) begin
      set_ivc = ~cmd_known(rx_data) | (slave_s_q &
        (rx_data == `CMD_CEILING || rx_data == `CMD_SLEW ||
        rx_data == `CMD_SCALE));
    end else if (rx_pulse && idx_q == 2'h1 && ack_q) begin
      if (cmd_q == `CMD_SCALE) set_bad = ~scale_legal(word);
      if (cmd_q == `CMD_CEILING) set_bad = |rx_data[7:4] |
        ~ceil_ok(word[11:0], scale_q);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      slave_m_q <= 1'b0;
      slave_s_q <= 1'b0;
      ceil_q <= `CEIL_RST;
      slew_q <= `SLEW_RST;
      scale_q <= `SCALE_RST;
      nvm_q <= `SCALE_RST;
      target_q <= 12'h000;
      ref_q <= 12'h000;
      ramp_q <= 3'h0;
      cmd_q <= `NO_DATA;
      lo_q <= 8'h00;
      tx_q <= `NO_DATA;
      idx_q <= 2'h0;
      ridx_q <= 2'h0;
      {ack_q, store_q, limit_chg_q} <= 3'h0;
      {cml_q, ivd_q, ivc_q, oth_q, vfw_q, warn_q, alert_q} <= 7'h00;
    end else begin
      // Strap is a pin level; it passes two stages before use
      slave_m_q <= loop_slave_pin;
      slave_s_q <= slave_m_q;
      store_q <= 1'b0;
      limit_chg_q <= 1'b0;
      if (target_load) target_q <= target_req;
      // Clamp always; the warning is only raised while the output is on
      ref_q <= prod[`REF_LSB +: 12];
      if (soft_start) ramp_q <= ton_rise_code;
      else if (turn_off) ramp_q <= toff_fall_code;
      else ramp_q <= rate_bucket(slew_q);
      if (rx_pulse && rx_first) begin
        // Refused commands read back as all ones
        cmd_q <= set_ivc ? `NO_DATA : rx_data;
        idx_q <= 2'h0;
        ack_q <= ~set_ivc;
        if (!set_ivc && rx_data == `CMD_STORE_ALL) begin
          store_q <= 1'b1;
          nvm_q <= scale_q;
        end
      end else if (rx_pulse) begin
        if (idx_q != 2'h3) idx_q <= idx_q + 2'h1;
        if (idx_q == 2'h0) begin
          lo_q <= rx_data;
          ack_q <= ack_q & (cmd_q != `CMD_STORE_ALL);
        end else if (idx_q == 2'h1 && ack_q) begin
          ack_q <= ~set_bad;
          if (cmd_q == `CMD_SLEW) slew_q <= word[6:0];
          // Accepted whatever the output state is
          if (cmd_q == `CMD_SCALE && !set_bad) begin
            scale_q <= word[2:0];
            ceil_q <= ceil_default(word[2:0]);
            limit_chg_q <= 1'b1;
          end
          if (cmd_q == `CMD_CEILING && !set_bad) begin
            ceil_q <= word[11:0];
            limit_chg_q <= 1'b1;
          end
        end else begin
          ack_q <= 1'b0;
        end
      end
      if (tx_req) begin
        ridx_q <= tx_first ? 2'h1 : 2'h2;
        if (tx_first) tx_q <= rd_word[7:0];
        else if (ridx_q == 2'h1) tx_q <= rd_word[15:8];
        else tx_q <= `NO_DATA;
      end
      cml_q <= (cml_q & ~clear_faults) | set_bad | set_ivc;
      ivd_q <= (ivd_q & ~clear_faults) | set_bad;
      ivc_q <= (ivc_q & ~clear_faults) | set_ivc;
      oth_q <= (oth_q & ~clear_faults) | set_warn;
      vfw_q <= (vfw_q & ~clear_faults) | set_warn;
      warn_q <= (warn_q & ~clear_faults) | set_warn;
      alert_q <= ((cml_q | ivd_q | ivc_q | oth_q | vfw_q | warn_q) &
        ~clear_faults) | set_bad | set_ivc | set_warn;
    end
  end
endmodule // vout_limit_slew_scale_regs

//--- verif/vout_limit_slew_scale_regs_monitor.sv
// Concurrent checks on the output-settings block ports
`timescale 1ns/1ps
module vout_limit_slew_scale_regs_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic smbalert_oe_n,
  input wire logic soft_start,
  input wire logic [2:0] ton_rise_code,
  input wire logic output_on,
  input wire logic [2:0] ramp_rate_code,
  input wire logic [11:0] ref_code,
  input wire logic [11:0] ceiling,
  input wire logic [2:0] scale_mant,
  input wire logic nvm_store,
  input wire logic [2:0] nvm_scale,
  input wire logic cml_flag,
  input wire logic ivd_flag,
  input wire logic invalid_command_fault,
  input wire logic oth_flag,
  input wire logic vfw_flag,
  input wire logic vout_maxmin_warn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ivd_alert;
    $rose(ivd_flag) |-> cml_flag && !smbalert_oe_n;
  endproperty
  a_ivd_alert: assert property (p_ivd_alert)
    else $error("bad data without cml or alert");
  property p_icf_alert;
    $rose(invalid_command_fault) |-> !smbalert_oe_n;
  endproperty
  a_icf_alert: assert property (p_icf_alert)
    else $error("invalid command without alert");
  property p_scale_ok;
    scale_mant inside {3'h1, 3'h2, 3'h4};
  endproperty
  a_scale_ok: assert property (p_scale_ok)
    else $error("illegal loop scale held");
  // Slack of two cycles for the default reload after a scale change
  property p_ceil_x1;
    (scale_mant == 3'h4) [*3] |-> ceiling inside {[12'h11A:12'h34D]};
  endproperty
  a_ceil_x1: assert property (p_ceil_x1)
    else $error("ceiling outside unity-scale range");
  property p_rise;
    (soft_start && $stable(ton_rise_code)) [*3] |->
      ramp_rate_code == ton_rise_code;
  endproperty
  a_rise: assert property (p_rise)
    else $error("soft-start ramp not on rise code");
  property p_clamp;
    ($stable(ceiling) && $stable(scale_mant)) [*4] |->
      ref_code <= (({3'h0, ceiling} * scale_mant) >> 2);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("reference above ceiling");
  property p_warn;
    $rose(vout_maxmin_warn) |->
      $past(output_on) && oth_flag && vfw_flag && !smbalert_oe_n;
  endproperty
  a_warn: assert property (p_warn)
    else $error("ceiling warning incomplete");
  property p_store;
    nvm_store |-> ##[0:1] nvm_scale == scale_mant;
  endproperty
  a_store: assert property (p_store)
    else $error("stored scale mismatch");
  c_warn: cover property ($rose(vout_maxmin_warn));
  c_store: cover property (nvm_store);
  c_icf: cover property ($rose(invalid_command_fault));
endmodule // vout_limit_slew_scale_regs_monitor

//--- verif/pmbus_host_model.sv
// Bus host model: word writes, word reads and send-byte
`timescale 1ns/1ps
module pmbus_host_model #(
  parameter [6:0] ADDR = 7'h24
) (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  logic [8:0] r;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Clock stands high between frames
  task automatic start();
    #40 sda_drv = 1'b1;
    #120 scl = 1'b1;
    #80 sda_drv = 1'b0;
    #80 scl = 1'b0;
  endtask
  task automatic stop();
    #40 sda_drv = 1'b0;
    #120 scl = 1'b1;
    #80 sda_drv = 1'b1;
    #80;
  endtask
  // Data moves a quarter into the low phase, clear of both clock edges
  task automatic xfer(input [8:0] o);
    for (int k = 8; k >= 0; k--) begin
      #40 sda_drv = o[k];
      #120 scl = 1'b1;
      #80 r[k] = sda;
      #80 scl = 1'b0;
    end
  endtask
  task automatic wr(input [7:0] c, input [15:0] w, output [3:0] a);
    start();
    xfer({ADDR, 2'b01});
    a[3] = !r[0];
    xfer({c, 1'b1});
    a[2] = !r[0];
    xfer({w[7:0], 1'b1});
    a[1] = !r[0];
    xfer({w[15:8], 1'b1});
    a[0] = !r[0];
    stop();
  endtask
  task automatic rd(input [7:0] c, output [15:0] w, output [1:0] a);
    start();
    xfer({ADDR, 2'b01});
    xfer({c, 1'b1});
    a[1] = !r[0];
    start();
    xfer({ADDR, 2'b11});
    a[0] = !r[0];
    xfer({8'hFF, 1'b0});
    w[7:0] = r[8:1];
    xfer(9'h1FF);
    w[15:8] = r[8:1];
    stop();
  endtask
  task automatic sb(input [7:0] c, output a);
    start();
    xfer({ADDR, 2'b01});
    xfer({c, 1'b1});
    a = !r[0];
    stop();
  endtask
endmodule // pmbus_host_model

//--- verif/vout_limit_slew_scale_regs_tb.sv
// Self-checking bench for the ceiling, slew and loop-scale block
`timescale 1ns/1ps
`include "vout_limit_regs.vh"
module vout_limit_slew_scale_regs_tb;
  logic clk = 1'b0, rst = 1'b1, loop_slave_pin = 1'b0, output_on = 1'b0;
  logic soft_start = 1'b0, turn_off = 1'b0, target_load = 1'b0;
  logic clear_faults = 1'b0, stored = 1'b0;
  logic [2:0] ton_rise_code = 3'h1, toff_fall_code = 3'h3;
  logic [11:0] target_req = 12'h000;
  wire scl_pin, sda_drv, sda_out, sda_oe_n, smbalert_out, smbalert_oe_n;
  wire [2:0] ramp_rate_code, scale_mant, nvm_scale;
  wire [11:0] ref_code, ceiling;
  wire nvm_store, cml_flag, ivd_flag, invalid_command_fault;
  wire oth_flag, vfw_flag, vout_maxmin_warn;
  wire sda_pin = sda_drv & (sda_oe_n | sda_out);
  int num_errors = 0;
  int samples_checked = 0;
  logic [3:0] a;
  logic [15:0] w;
  logic [6:0] mt [16] = '{7'h05, 7'h06, 7'h07, 7'h08, 7'h0C, 7'h0D, 7'h11,
    7'h12, 7'h19, 7'h1A, 7'h2F, 7'h30, 7'h4F, 7'h50, 7'h00, 7'h7F};
  logic [2:0] sm [3] = '{3'h2, 3'h1, 3'h4};
  logic [11:0] cn [3] = '{12'h234, 12'h468, 12'h11A};
  logic [11:0] cx [3] = '{12'h69A, 12'hC00, 12'h34D};
  vout_limit_slew_scale_regs dut (
    .clk(clk),
    .rst(rst),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .smbalert_out(smbalert_out),
    .smbalert_oe_n(smbalert_oe_n),
    .loop_slave_pin(loop_slave_pin),
    .output_on(output_on),
    .soft_start(soft_start),
    .turn_off(turn_off),
    .ton_rise_code(ton_rise_code),
    .toff_fall_code(toff_fall_code),
    .target_req(target_req),
    .target_load(target_load),
    .clear_faults(clear_faults),
    .ramp_rate_code(ramp_rate_code),
    .ref_code(ref_code),
    .ceiling(ceiling),
    .scale_mant(scale_mant),
    .nvm_store(nvm_store),
    .nvm_scale(nvm_scale),
    .cml_flag(cml_flag),
    .ivd_flag(ivd_flag),
    .invalid_command_fault(invalid_command_fault),
    .oth_flag(oth_flag),
    .vfw_flag(vfw_flag),
    .vout_maxmin_warn(vout_maxmin_warn)
  );
  pmbus_host_model host (.scl(scl_pin), .sda_drv(sda_drv), .sda(sda_pin));
  always #20 clk = ~clk;
  always @(posedge clk) if (nvm_store === 1'b1) stored <= 1'b1;
  task automatic chk(input string n, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input [7:0] c, input [15:0] d, input [3:0] ea);
    host.wr(c, d, a);
    cyc(3);
    chk("write ack", a, ea);
  endtask
  task automatic rd(input [7:0] c, input [15:0] e, input [1:0] ea);
    host.rd(c, w, a[1:0]);
    chk("read ack", a[1:0], ea);
    chk("read word", w, e);
  endtask
  task automatic clr();
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(2);
    chk("flags", {cml_flag, ivd_flag, invalid_command_fault, oth_flag,
      vfw_flag, vout_maxmin_warn, smbalert_oe_n, smbalert_out}, 8'h02);
  endtask
  task automatic t_reset();
    chk("ceiling", ceiling, 12'h34D);
    chk("scale", {nvm_scale, scale_mant}, 6'h24);
    chk("rate", ramp_rate_code, 3'h6);
    rd(`CMD_SLEW, 16'hD03C, 2'h3);
    rd(`CMD_SCALE, 16'hF004, 2'h3);
    rd(`CMD_CEILING, 16'h034D, 2'h3);
    clr();
    $display("reset test done");
  endtask
  task automatic t_slew();
    logic [6:0] m;
    for (int i = 0; i < 16; i++) begin
      m = mt[i];
      wr(`CMD_SLEW, {8'hFF, 1'b1, m}, 4'hF);
      chk("rate", ramp_rate_code, (m > 7'h05) + (m > 7'h07) + (m > 7'h0C)
        + (m > 7'h11) + (m > 7'h19) + (m > 7'h2F) + (m > 7'h4F));
      rd(`CMD_SLEW, {9'h1A0, m}, 2'h3);
    end
    soft_start = 1'b1;
    ton_rise_code = 3'h2;
    cyc(4);
    chk("rise rate", ramp_rate_code, 3'h2);
    soft_start = 1'b0;
    turn_off = 1'b1;
    cyc(4);
    chk("fall rate", ramp_rate_code, 3'h3);
    turn_off = 1'b0;
    cyc(4);
    chk("slew rate", ramp_rate_code, 3'h7);
    $display("slew test done");
  endtask
  task automatic t_scale();
    for (int i = 0; i < 3; i++) begin
      wr(`CMD_SCALE, {13'h1E00, sm[i]}, 4'hF);
      chk("scale", scale_mant, sm[i]);
      wr(`CMD_CEILING, cn[i] - 12'h001, 4'hE);
      wr(`CMD_CEILING, cx[i] + 12'h001, 4'hE);
      chk("ceiling", ceiling, cx[i]);
      chk("bad data", {cml_flag, ivd_flag, smbalert_oe_n}, 3'h6);
      clr();
      wr(`CMD_CEILING, cn[i], 4'hF);
      rd(`CMD_CEILING, cn[i], 2'h3);
      wr(`CMD_CEILING, cx[i], 4'hF);
      chk("ceiling", ceiling, cx[i]);
    end
    output_on = 1'b1;
    wr(`CMD_SCALE, 16'hF003, 4'hE);
    chk("bad scale", {scale_mant, cml_flag, ivd_flag, smbalert_oe_n},
      6'h26);
    clr();
    wr(`CMD_SCALE, 16'hF002, 4'hF);
    chk("scale", scale_mant, 3'h2);
    target_req = 12'hFFF;
    target_load = 1'b1;
    cyc(1);
    target_load = 1'b0;
    cyc(3);
    chk("clamp", ref_code, 12'h34D);
    chk("warn", {oth_flag, vfw_flag, vout_maxmin_warn}, 3'h7);
    output_on = 1'b0;
    clr();
    $display("scale test done");
  endtask
  task automatic t_store();
    host.sb(`CMD_STORE_ALL, a[0]);
    cyc(3);
    chk("store", {a[0], stored, nvm_scale}, 5'h1A);
    host.sb(8'h5A, a[1]);
    cyc(3);
    chk("unknown", {a[1], invalid_command_fault}, 2'h1);
    clr();
    $display("store test done");
  endtask
  task automatic t_slave();
    loop_slave_pin = 1'b1;
    cyc(4);
    wr(`CMD_SLEW, 16'h0005, 4'h8);
    chk("slave", {ramp_rate_code, invalid_command_fault, smbalert_oe_n},
      5'h1E);
    clr();
    rd(`CMD_SCALE, 16'hFFFF, 2'h1);
    chk("slave", invalid_command_fault, 1'b1);
    loop_slave_pin = 1'b0;
    cyc(4);
    clr();
    rd(`CMD_SLEW, 16'hD07F, 2'h3);
    $display("slave test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(6);
    t_reset();
    t_slew();
    t_scale();
    t_store();
    t_slave();
    end_of_test();
  end
  // Run needs about 0.8 milliseconds
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end
endmodule // vout_limit_slew_scale_regs_tb
bind vout_limit_slew_scale_regs vout_limit_slew_scale_regs_monitor mon (
  .clk(clk),
  .rst(rst),
  .smbalert_oe_n(smbalert_oe_n),
  .soft_start(soft_start),
  .ton_rise_code(ton_rise_code),
  .output_on(output_on),
  .ramp_rate_code(ramp_rate_code),
  .ref_code(ref_code),
  .ceiling(ceiling),
  .scale_mant(scale_mant),
  .nvm_store(nvm_store),
  .nvm_scale(nvm_scale),
  .cml_flag(cml_flag),
  .ivd_flag(ivd_flag),
  .invalid_command_fault(invalid_command_fault),
  .oth_flag(oth_flag),
  .vfw_flag(vfw_flag),
  .vout_maxmin_warn(vout_maxmin_warn)
);
